/* File: rtl/cpu_programmer_register_set.sv */
// Programmer-visible register set of the processor core
// Summary of operation
// RULE_01: Eight data, seven address, PC, two stacks, status, two space codes, vector base.
// RULE_02: Data operands are the low 8, 16 or all 32 bits by size.
// RULE_03: Byte or word writes to data registers leave upper bits unchanged.
// RULE_04: Bit 0 is least significant, bit 31 most significant.
// RULE_05: 64-bit values sit in any two freely chosen data registers.
// RULE_06: Packed decimal byte: low digit in low nibble, high digit upper nibble.
// RULE_07: Address registers give low word or long word, never a byte.
// RULE_08: Address register writes change all bits; words are sign-extended.
// RULE_09: PC holds next instruction; advanced or loaded during execution.
// RULE_10: Control registers need supervisor privilege, except the flag byte.
// RULE_11: Status low byte holds extend, negative, zero, overflow, carry flags.
// RULE_12: User level sees only flag byte; supervisor sees full status word.
// RULE_13: Status upper byte: three-bit mask, two trace bits, privilege bit.
// RULE_14: Undefined status bits always read as zero.
// RULE_15: Software should write zero to undefined status bits.
// RULE_16: Flag byte accesses are words; upper byte reads zero, ignores writes.
// RULE_17: Source and destination space-code registers hold 3-bit codes.
// RULE_18: Space codes extend 24-bit addresses to eight 16-Mbyte spaces.
// RULE_19: Alternate-space alternate_space_move take their code from the space registers.
// RULE_20: Space-code alternate_space_move are long words; upper 29 bits zero, writes ignored.
// RULE_21: Vector base locates a 1024-byte table of 256 vectors.
// RULE_22: Vector address is upper 22 base bits joined to vector number times four.
// RULE_23: Privilege bit selects privilege level and active stack pointer.
// RULE_24: User access to supervisor registers changes nothing, flags violation.
// RULE_25: Writes land on the clock edge; next-cycle reads see them.
module cpu_programmer_register_set (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] dataRdSel,
  input wire regset_pkg::op_size_t dataRdSize,
  output logic [31:0] dataRdValue,
  input wire logic [2:0] data2RdSel,
  output logic [31:0] data2RdValue,
  input wire logic dataWrEn,
  input wire logic [2:0] dataWrSel,
  input wire regset_pkg::op_size_t dataWrSize,
  input wire logic [31:0] dataWrValue,
  input wire logic data2WrEn,
  input wire logic [2:0] data2WrSel,
  input wire logic [31:0] data2WrValue,
  input wire logic [2:0] addrRdSel,
  input wire regset_pkg::op_size_t addrRdSize,
  output logic [31:0] addrRdValue,
  input wire logic addrWrEn,
  input wire logic [2:0] addrWrSel,
  input wire regset_pkg::op_size_t addrWrSize,
  input wire logic [31:0] addrWrValue,
  output logic [31:0] stackPointer,
  input wire logic stackWrEn,
  input wire logic [31:0] stackWrValue,
  output logic [31:0] nextInstrPointer,
  input wire regset_pkg::pc_op_t pcOp,
  input wire logic [31:0] pcStep,
  input wire logic [31:0] pcLoadValue,
  input wire logic flagsWrEn,
  input wire logic [4:0] flagsWrValue,
  output logic [4:0] conditionFlags,
  input wire logic excEntry,
  input wire logic [15:0] excStatusValue,
  input wire regset_pkg::ctl_sel_t ctlSel,
  input wire logic ctlRdEn,
  input wire logic ctlWrEn,
  input wire logic [31:0] ctlWrValue,
  output logic [31:0] ctlRdValue,
  output logic privViolation,
  output logic [15:0] statusWord,
  output logic supervisorMode,
  output logic [2:0] interruptPriorityMask,
  output logic [1:0] traceMode,
  output logic [2:0] sourceSpaceCode,
  output logic [2:0] destSpaceCode,
  input wire logic [7:0] vectorNumber,
  output logic [31:0] vectorAddress
);
  typedef struct packed {
    logic [regset_pkg::NumData-1:0][31:0] dataRegs; // RULE_01 RULE_04
    logic [regset_pkg::NumAddr-1:0][31:0] addrRegs; // RULE_01
    logic [31:0] userStack;
    logic [31:0] superStack;
    logic [31:0] pc;
    logic [15:0] status;
    logic [2:0] srcSpace;
    logic [2:0] dstSpace;
    logic [31:0] vectorBase;
    logic [31:0] ctlRd;
    logic violation;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic [31:0] dataRdRaw;
  logic [31:0] dataMerged;
  logic [31:0] addrRdRaw;
  logic [31:0] addrMerged;
  logic [31:0] addrOld;
  logic [31:0] addrRdSlice;
  logic isSuper;
  logic ctlNeedsSuper;

  function automatic logic [15:0] cleanStatus(input logic [15:0] value);
    cleanStatus = value & regset_pkg::StatusDefinedMask; // RULE_14
  endfunction

  function automatic logic [31:0] pickAddr(input logic [2:0] sel, input state_t s,
                                           input logic superSel);
    if (sel == 3'h7) begin
      pickAddr = superSel ? s.superStack : s.userStack; // RULE_23
    end else begin
      pickAddr = s.addrRegs[sel];
    end
  endfunction

  assign isSuper = state_q.status[regset_pkg::PrivBit]; // RULE_23
  assign dataRdRaw = state_q.dataRegs[dataRdSel];
  assign addrRdRaw = pickAddr(addrRdSel, state_q, isSuper);
  assign addrOld = pickAddr(addrWrSel, state_q, isSuper);

  operand_slicer dataReadSlicer (
    .oldValue(dataRdRaw),
    .newValue(dataRdRaw),
    .opSize(dataRdSize),
    .isAddress(1'b0),
    .readSlice(dataRdValue),
    .mergedValue()
  );

  operand_slicer dataWriteSlicer (
    .oldValue(state_q.dataRegs[dataWrSel]),
    .newValue(dataWrValue),
    .opSize(dataWrSize),
    .isAddress(1'b0),
    .readSlice(),
    .mergedValue(dataMerged)
  );

  operand_slicer addrReadSlicer (
    .oldValue(addrRdRaw),
    .newValue(addrRdRaw),
    .opSize(addrRdSize),
    .isAddress(1'b1),
    .readSlice(addrRdSlice),
    .mergedValue()
  );

  operand_slicer addrWriteSlicer (
    .oldValue(addrOld),
    .newValue(addrWrValue),
    .opSize(addrWrSize),
    .isAddress(1'b1),
    .readSlice(),
    .mergedValue(addrMerged)
  );

  assign addrRdValue = addrRdSlice;
  assign data2RdValue = state_q.dataRegs[data2RdSel]; // RULE_05
  assign ctlNeedsSuper = (ctlSel != regset_pkg::CtlFlags) && (ctlSel != regset_pkg::CtlNone);

  always_comb begin
    state_d = state_q;
    state_d.violation = 1'b0;
    state_d.ctlRd = regset_pkg::WordZero;
    if (dataWrEn) begin
      state_d.dataRegs[dataWrSel] = dataMerged; // RULE_03
    end
    if (data2WrEn) begin
      state_d.dataRegs[data2WrSel] = data2WrValue; // RULE_05
    end
    if (addrWrEn) begin
      if (addrWrSel == 3'h7) begin
        if (isSuper) begin
          state_d.superStack = addrMerged; // RULE_08
        end else begin
          state_d.userStack = addrMerged;
        end
      end else begin
        state_d.addrRegs[addrWrSel] = addrMerged; // RULE_08
      end
    end
    if (stackWrEn) begin
      if (isSuper) begin
        state_d.superStack = stackWrValue; // RULE_23
      end else begin
        state_d.userStack = stackWrValue;
      end
    end
    case (pcOp)
      regset_pkg::PcAdvance: state_d.pc = state_q.pc + pcStep; // RULE_09
      regset_pkg::PcLoad: state_d.pc = pcLoadValue; // RULE_09
      default: state_d.pc = state_q.pc;
    endcase
    if (flagsWrEn) begin
      state_d.status[4:0] = flagsWrValue; // RULE_11
    end
    if ((ctlRdEn || ctlWrEn) && ctlNeedsSuper && !isSuper) begin
      state_d.violation = 1'b1; // RULE_24
    end else if (ctlRdEn || ctlWrEn) begin
      if (ctlSel == regset_pkg::CtlStatus) begin
        state_d.ctlRd = {16'h0000, cleanStatus(state_q.status)}; // RULE_12
        if (ctlWrEn) begin
          state_d.status = cleanStatus(ctlWrValue[15:0]); // RULE_14
        end
      end else if (ctlSel == regset_pkg::CtlFlags) begin
        state_d.ctlRd = {16'h0000, state_q.status & regset_pkg::FlagByteMask}; // RULE_16
        if (ctlWrEn) begin
          state_d.status[7:0] = ctlWrValue[7:0] & regset_pkg::FlagByteMask[7:0]; // RULE_16
        end
      end else if (ctlSel == regset_pkg::CtlSrcSpace) begin
        state_d.ctlRd = {29'h0, state_q.srcSpace}; // RULE_20
        if (ctlWrEn) begin
          state_d.srcSpace = ctlWrValue[2:0]; // RULE_17
        end
      end else if (ctlSel == regset_pkg::CtlDstSpace) begin
        state_d.ctlRd = {29'h0, state_q.dstSpace}; // RULE_20
        if (ctlWrEn) begin
          state_d.dstSpace = ctlWrValue[2:0]; // RULE_17
        end
      end else if (ctlSel == regset_pkg::CtlVectorBase) begin
        state_d.ctlRd = state_q.vectorBase; // RULE_10
        if (ctlWrEn) begin
          state_d.vectorBase = ctlWrValue; // RULE_21
        end
      end else if (ctlSel == regset_pkg::CtlUserStack) begin
        state_d.ctlRd = state_q.userStack; // RULE_10
        if (ctlWrEn) begin
          state_d.userStack = ctlWrValue;
        end
      end else begin
        state_d.ctlRd = regset_pkg::WordZero;
      end
    end
    if (excEntry) begin
      state_d.status = cleanStatus(excStatusValue); // RULE_23
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= '0;
      state_q.status <= regset_pkg::StatusResetValue;
    end else begin
      state_q <= state_d; // RULE_25
    end
  end

  assign ctlRdValue = state_q.ctlRd;
  assign privViolation = state_q.violation;
  assign statusWord = cleanStatus(state_q.status); // RULE_14
  assign conditionFlags = state_q.status[regset_pkg::FlagExtend:regset_pkg::FlagCarry]; // RULE_11
  assign supervisorMode = isSuper;
  assign interruptPriorityMask = state_q.status[regset_pkg::MaskLsb +: 3]; // RULE_13
  assign traceMode = state_q.status[regset_pkg::TraceLsb +: 2]; // RULE_13
  assign sourceSpaceCode = state_q.srcSpace; // RULE_18 RULE_19
  assign destSpaceCode = state_q.dstSpace; // RULE_19
  assign stackPointer = isSuper ? state_q.superStack : state_q.userStack; // RULE_23
  assign nextInstrPointer = state_q.pc;
  assign vectorAddress = {state_q.vectorBase[31:regset_pkg::VbrKeepLsb], vectorNumber, 2'b00}; // RULE_22
endmodule

/* File: rtl/operand_slicer.sv */
// Operand size slicing and merge for data and address registers
module operand_slicer (
  input wire logic [31:0] oldValue,
  input wire logic [31:0] newValue,
  input wire regset_pkg::op_size_t opSize,
  input wire logic isAddress,
  output logic [31:0] readSlice,
  output logic [31:0] mergedValue
);
  always_comb begin
    readSlice = oldValue;
    mergedValue = newValue;
    if (isAddress) begin
      if (opSize != regset_pkg::SizeLong) begin
        readSlice = {16'h0000, oldValue[15:0]}; // RULE_07
        mergedValue = {{16{newValue[15]}}, newValue[15:0]}; // RULE_08
      end
    end else begin
      case (opSize)
        regset_pkg::SizeByte: begin
          readSlice = {24'h000000, oldValue[7:0]}; // RULE_02 RULE_06
          mergedValue = {oldValue[31:8], newValue[7:0]}; // RULE_03
        end
        regset_pkg::SizeWord: begin
          readSlice = {16'h0000, oldValue[15:0]}; // RULE_02
          mergedValue = {oldValue[31:16], newValue[15:0]}; // RULE_03
        end
        default: begin
          readSlice = oldValue;
          mergedValue = newValue;
        end
      endcase
    end
  end
endmodule

/* File: rtl/regset_pkg.sv */
// Constants and types for the programmer register set
package regset_pkg;
  localparam int unsigned DataWidth = 32;
  localparam int unsigned StatusWidth = 16;
  localparam int unsigned NumData = 8;
  localparam int unsigned NumAddr = 7;
  localparam int unsigned RegIdxWidth = 3;
  localparam int unsigned SpaceCodeWidth = 3;
  localparam int unsigned VectorNumWidth = 8;
  localparam int unsigned VbrKeepLsb = 10;
  localparam int unsigned VectorShift = 2;
  localparam int unsigned FlagCarry = 0;
  localparam int unsigned FlagOverflow = 1;
  localparam int unsigned FlagZero = 2;
  localparam int unsigned FlagNegative = 3;
  localparam int unsigned FlagExtend = 4;
  localparam int unsigned MaskLsb = 8;
  localparam int unsigned PrivBit = 13;
  localparam int unsigned TraceLsb = 14;
  localparam logic [15:0] StatusDefinedMask = 16'he71f;
  localparam logic [15:0] FlagByteMask = 16'h001f;
  localparam logic [15:0] StatusResetValue = 16'h2700;
  localparam logic [31:0] WordZero = 32'h0000_0000;
  localparam logic [31:0] SpaceCodeMask = 32'h0000_0007;

  typedef enum logic [1:0] {
    SizeByte = 2'b00,
    SizeWord = 2'b01,
    SizeLong = 2'b10
  } op_size_t;

  typedef enum logic [2:0] {
    CtlNone = 3'b000,
    CtlStatus = 3'b001,
    CtlFlags = 3'b010,
    CtlSrcSpace = 3'b011,
    CtlDstSpace = 3'b100,
    CtlVectorBase = 3'b101,
    CtlUserStack = 3'b110
  } ctl_sel_t;

  typedef enum logic [1:0] {
    PcHold = 2'b00,
    PcAdvance = 2'b01,
    PcLoad = 2'b10
  } pc_op_t;
endpackage

/* File: testbench/cpu_programmer_register_set_asserts.sv */
// Assertion checker for the programmer register set
module cpu_programmer_register_set_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic flagsWrEn,
  input wire logic [4:0] flagsWrValue,
  input wire logic excEntry,
  input wire logic [15:0] excStatusValue,
  input wire regset_pkg::ctl_sel_t ctlSel,
  input wire logic ctlRdEn,
  input wire logic ctlWrEn,
  input wire logic [31:0] ctlRdValue,
  input wire logic privViolation,
  input wire regset_pkg::pc_op_t pcOp,
  input wire logic [31:0] pcStep,
  input wire logic [31:0] nextInstrPointer,
  input wire logic [4:0] conditionFlags,
  input wire logic [15:0] statusWord,
  input wire logic supervisorMode,
  input wire logic [2:0] interruptPriorityMask,
  input wire logic [2:0] sourceSpaceCode,
  input wire logic [7:0] vectorNumber,
  input wire logic [31:0] vectorAddress
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic anyCtl;
  logic userCtl;
  assign anyCtl = ctlRdEn || ctlWrEn;
  assign userCtl = anyCtl && !supervisorMode && ctlSel != regset_pkg::CtlNone
                   && ctlSel != regset_pkg::CtlFlags;
  a_undef_zero: assert property (
    (statusWord & ~regset_pkg::StatusDefinedMask) == 16'h0000) else $error("undefined bits set");
  a_upper_fields: assert property (
    supervisorMode == statusWord[13] && interruptPriorityMask == statusWord[10:8])
    else $error("status fields differ");
  a_user_refused: assert property (userCtl |=> privViolation)
    else $error("user access not refused");
  a_super_allowed: assert property (anyCtl && supervisorMode |=> !privViolation)
    else $error("supervisor access refused");
  a_space_read: assert property (
    ctlRdEn && supervisorMode && ctlSel == regset_pkg::CtlSrcSpace
    |=> ctlRdValue == {29'h0, $past(sourceSpaceCode)}) else $error("space code read bad");
  a_vector_low: assert property (
    vectorAddress[9:0] == {vectorNumber, 2'h0}) else $error("vector address bad");
  a_pc_advance: assert property (
    pcOp == regset_pkg::PcAdvance |=> nextInstrPointer == $past(nextInstrPointer) + $past(pcStep))
    else $error("pointer advance bad");
  a_exc_load: assert property (
    excEntry |=> statusWord == ($past(excStatusValue) & regset_pkg::StatusDefinedMask))
    else $error("exception status bad");
  a_flags_write: assert property (
    flagsWrEn && !excEntry && !ctlWrEn |=> conditionFlags == $past(flagsWrValue))
    else $error("flag write bad");
  c_user_refused: cover property (userCtl);
  c_exc_entry: cover property (excEntry);
  c_pc_advance: cover property (pcOp == regset_pkg::PcAdvance);
endmodule
bind cpu_programmer_register_set cpu_programmer_register_set_asserts i_chk (.*);

/* File: testbench/tb_top.sv */
// Self-checking bench for the programmer register set
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, reset = 1'h1, privViolation, supervisorMode;
  logic dataWrEn = 1'h0, data2WrEn = 1'h0, addrWrEn = 1'h0, stackWrEn = 1'h0;
  logic flagsWrEn = 1'h0, excEntry = 1'h0, ctlRdEn = 1'h0, ctlWrEn = 1'h0;
  logic [1:0] traceMode;
  logic [2:0] dataRdSel = 3'h0, data2RdSel = 3'h0, dataWrSel = 3'h0, data2WrSel = 3'h0;
  logic [2:0] addrRdSel = 3'h0, addrWrSel = 3'h0, interruptPriorityMask;
  logic [2:0] sourceSpaceCode, destSpaceCode;
  logic [4:0] flagsWrValue = 5'h0, conditionFlags;
  logic [7:0] vectorNumber = 8'h0;
  logic [15:0] excStatusValue = 16'h0, statusWord;
  logic [31:0] dataWrValue = 32'h0, data2WrValue = 32'h0, addrWrValue = 32'h0;
  logic [31:0] stackWrValue = 32'h0, pcStep = 32'h0, pcLoadValue = 32'h0, ctlWrValue = 32'h0;
  logic [31:0] dataRdValue, data2RdValue, addrRdValue, stackPointer, nextInstrPointer;
  logic [31:0] ctlRdValue, vectorAddress;
  regset_pkg::op_size_t dataRdSize = regset_pkg::SizeLong, dataWrSize = regset_pkg::SizeLong;
  regset_pkg::op_size_t addrRdSize = regset_pkg::SizeLong, addrWrSize = regset_pkg::SizeWord;
  regset_pkg::pc_op_t pcOp = regset_pkg::PcHold;
  regset_pkg::ctl_sel_t ctlSel = regset_pkg::CtlNone;
  int fail_count = 0;
  int comparisons = 0;
  cpu_programmer_register_set i_dut (.*);
  always #2 core_clk = ~core_clk;
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One control access: selector, write or read, value
  task automatic ctl(input logic [2:0] s, input logic wr, input logic [31:0] v);
    ctlSel = regset_pkg::ctl_sel_t'(s);
    ctlWrEn = wr;
    ctlRdEn = !wr;
    ctlWrValue = v;
    step();
  endtask
  // Ends a run of control accesses
  task automatic ctl_off();
    ctlWrEn = 1'h0;
    ctlRdEn = 1'h0;
    ctlSel = regset_pkg::CtlNone;
  endtask
  task automatic dwr(input logic [2:0] s, input regset_pkg::op_size_t z, input logic [31:0] v);
    dataWrEn = 1'h1;
    dataWrSel = s;
    dataWrSize = z;
    dataWrValue = v;
    step();
  endtask
  task automatic t_data();
    dwr(3'h3, regset_pkg::SizeLong, 32'h8765_4321);
    dwr(3'h3, regset_pkg::SizeWord, 32'hffff_a5a5);
    dataRdSel = 3'h3;
    dwr(3'h3, regset_pkg::SizeByte, 32'hffff_ff47);
    chk(dataRdValue, 32'h8765_a547);
    dataRdSize = regset_pkg::SizeByte;
    step();
    chk(dataRdValue, 32'h0000_0047);
    dataRdSize = regset_pkg::SizeWord;
    step();
    chk(dataRdValue, 32'h0000_a547);
    dataRdSel = 3'h6;
    dataRdSize = regset_pkg::SizeLong;
    data2RdSel = 3'h1;
    data2WrEn = 1'h1;
    data2WrSel = 3'h1;
    data2WrValue = 32'hffff_fffe;
    dwr(3'h6, regset_pkg::SizeLong, 32'h0000_0001);
    chk(dataRdValue, 32'h0000_0001);
    chk(data2RdValue, 32'hffff_fffe);
    dataWrEn = 1'h0;
    data2WrEn = 1'h0;
    addrWrEn = 1'h1;
    addrWrSel = 3'h2;
    addrWrValue = 32'h1234_8001;
    addrRdSel = 3'h2;
    stackWrEn = 1'h1;
    stackWrValue = 32'h0000_4000;
    step();
    addrWrEn = 1'h0;
    stackWrEn = 1'h0;
    chk(addrRdValue, 32'hffff_8001);
    chk(stackPointer, 32'h0000_4000);
    addrRdSize = regset_pkg::SizeWord;
    step();
    chk(addrRdValue, 32'h0000_8001);
    $display("data and address test done");
  endtask
  task automatic t_status();
    chk(statusWord, 32'h0000_2700);
    ctl(3'h1, 1'h1, 32'h0000_ffff);
    chk(statusWord, 32'h0000_e71f);
    chk(traceMode, 32'h3);
    chk(interruptPriorityMask, 32'h7);
    chk(supervisorMode, 32'h1);
    ctl(3'h1, 1'h0, 32'h0);
    chk(ctlRdValue, 32'h0000_e71f);
    ctl(3'h1, 1'h1, 32'h0);
    chk(supervisorMode, 32'h0);
    chk(stackPointer, 32'h0);
    ctl(3'h5, 1'h1, 32'hffff_ffff);
    chk(privViolation, 32'h1);
    ctl(3'h2, 1'h1, 32'h0000_ff15);
    chk(privViolation, 32'h0);
    chk(statusWord, 32'h0000_0015);
    ctl(3'h2, 1'h0, 32'h0);
    chk(ctlRdValue, 32'h0000_0015);
    ctl_off();
    flagsWrEn = 1'h1;
    flagsWrValue = 5'h0a;
    step();
    flagsWrEn = 1'h0;
    chk(conditionFlags, 32'h0000_000a);
    excEntry = 1'h1;
    excStatusValue = 16'h2700;
    step();
    excEntry = 1'h0;
    chk(stackPointer, 32'h0000_4000);
    ctl(3'h5, 1'h0, 32'h0);
    chk(ctlRdValue, 32'h0);
    $display("status test done");
  endtask
  task automatic t_ctl();
    ctl(3'h3, 1'h1, 32'hffff_fffd);
    ctl(3'h4, 1'h1, 32'h0000_0002);
    chk(sourceSpaceCode, 32'h5);
    chk(destSpaceCode, 32'h2);
    ctl(3'h3, 1'h0, 32'h0);
    chk(ctlRdValue, 32'h0000_0005);
    vectorNumber = 8'h81;
    ctl(3'h5, 1'h1, 32'h1234_5678);
    chk(vectorAddress, 32'h1234_5604);
    ctl(3'h5, 1'h0, 32'h0);
    chk(ctlRdValue, 32'h1234_5678);
    ctl_off();
    pcOp = regset_pkg::PcLoad;
    pcLoadValue = 32'h0000_0100;
    step();
    pcOp = regset_pkg::PcAdvance;
    pcStep = 32'h0000_0004;
    step();
    pcOp = regset_pkg::PcHold;
    chk(nextInstrPointer, 32'h0000_0104);
    $display("control and pointer test done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1 reset = 1'h0;
    t_data();
    t_status();
    t_ctl();
    wrap_up();
  end
  initial begin
    #2000;
    fail_count++;
    wrap_up();
  end
endmodule
